// [core/jtbs_pkg.sv]
// package: constants, states and carriers of the test access port
package jtbs_pkg;
    localparam int IR_W = 10;
    localparam int SIG_W = 16;
    localparam int UCODE_W = 32;
    localparam int DR_W = 32;
    localparam int BSR_LEN_DEF = 288;
    localparam int SYNC_STAGES = 3;
    // instruction capture pattern, low two bits fixed at 01
    localparam logic [9:0] IR_CAPTURE = 10'h001;
    localparam logic [9:0] IR_RESET = 10'h059;
    // opcode encodings
    localparam logic [9:0] OP_EXTEST = 10'h000;
    localparam logic [9:0] OP_SAMPLE = 10'h055;
    localparam logic [9:0] OP_IDCODE = 10'h059;
    localparam logic [9:0] OP_USERCODE = 10'h007;
    localparam logic [9:0] OP_SIG_READ = 10'h056;
    localparam logic [9:0] OP_SIG_WRITE = 10'h057;
    localparam logic [9:0] OP_PROG_ENTER = 10'h202;
    localparam logic [9:0] OP_PROG_EXIT = 10'h201;
    localparam logic [9:0] OP_BYPASS = 10'h3FF;
    // identification fields, values arbitrary
    localparam logic [3:0] ID_VERSION = 4'h2;
    localparam logic [15:0] ID_PART = 16'h1234;
    localparam logic [10:0] ID_MAKER = 11'h2A5;
    localparam logic ID_ONE = 1'b1;
    localparam logic [15:0] SIG_RESET = 16'h0000;

    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
    } jtbs_tap_t;

    // the three test inputs sampled together
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } jtbs_pins_t;
endpackage

// [core/jtbs_port.sv]
// file: boundary-scan and in-system programming test access port
`timescale 1ns/1ns
`default_nettype none

module jtbs_port #(
    parameter int BSR_LEN = jtbs_pkg::BSR_LEN_DEF,
    parameter bit ENHANCED = 1'b1,
    parameter int NUM_IO = 8
) (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic clk_en_i,
    input wire logic jtag_en_i,
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    input wire logic programming_complete_flag_i,
    input wire logic [31:0] usercode_i,
    input wire logic [BSR_LEN-1:0] bsr_capture_i,
    input wire logic [NUM_IO-1:0] user_oe_i,
    output logic tdo_o,
    output logic tdo_oe_o,
    output logic test_pins_user_o,
    output logic prog_active_o,
    output logic io_pullup_o,
    output logic [NUM_IO-1:0] io_oe_o,
    output logic [15:0] user_sig_o,
    output logic [BSR_LEN-1:0] bsr_update_o
);
    localparam logic [31:0] IDCODE_VAL = {jtbs_pkg::ID_VERSION, jtbs_pkg::ID_PART,
                                          jtbs_pkg::ID_MAKER, jtbs_pkg::ID_ONE};

    jtbs_pkg::jtbs_pins_t s1_r, s2_r, s3_r, filt_r, filt_nxt, raw;
    jtbs_pkg::jtbs_tap_t tap_r, tap_nxt;
    logic [9:0] ir_sh_r, ir_r;
    logic [31:0] dr_sh_r;
    logic [BSR_LEN-1:0] bsr_sh_r;
    logic prog_r;
    logic tck_rise, tck_fall;

    function automatic logic is_op(input logic [9:0] ir, input logic [9:0] op);
        return ir == op;
    endfunction

    // three-stage sampling of the slow test pins
    assign raw = '{tck: tck_i, tms: tms_i, tdi: tdi_i};
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else if (clk_en_i) begin
            s1_r <= raw;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // a pin change counts only when stages two and three agree
    always_comb begin
        filt_nxt = filt_r;
        if (s2_r.tck == s3_r.tck) filt_nxt.tck = s3_r.tck;
        if (s2_r.tms == s3_r.tms) filt_nxt.tms = s3_r.tms;
        if (s2_r.tdi == s3_r.tdi) filt_nxt.tdi = s3_r.tdi;
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            filt_r <= '0;
        end else if (clk_en_i) begin
            filt_r <= filt_nxt;
        end
    end

    assign tck_rise = clk_en_i & filt_nxt.tck & ~filt_r.tck;
    assign tck_fall = clk_en_i & ~filt_nxt.tck & filt_r.tck;

    always_comb begin
        tap_nxt = tap_r;
        case (tap_r)
            jtbs_pkg::TLR: tap_nxt = filt_nxt.tms ? jtbs_pkg::TLR : jtbs_pkg::RTI;
            jtbs_pkg::RTI: tap_nxt = filt_nxt.tms ? jtbs_pkg::SEL_DR : jtbs_pkg::RTI;
            jtbs_pkg::SEL_DR: tap_nxt = filt_nxt.tms ? jtbs_pkg::SEL_IR : jtbs_pkg::CAP_DR;
            jtbs_pkg::CAP_DR: tap_nxt = filt_nxt.tms ? jtbs_pkg::EX1_DR : jtbs_pkg::SH_DR;
            jtbs_pkg::SH_DR: tap_nxt = filt_nxt.tms ? jtbs_pkg::EX1_DR : jtbs_pkg::SH_DR;
            jtbs_pkg::EX1_DR: tap_nxt = filt_nxt.tms ? jtbs_pkg::UPD_DR : jtbs_pkg::PAU_DR;
            jtbs_pkg::PAU_DR: tap_nxt = filt_nxt.tms ? jtbs_pkg::EX2_DR : jtbs_pkg::PAU_DR;
            jtbs_pkg::EX2_DR: tap_nxt = filt_nxt.tms ? jtbs_pkg::UPD_DR : jtbs_pkg::SH_DR;
            jtbs_pkg::UPD_DR: tap_nxt = filt_nxt.tms ? jtbs_pkg::SEL_DR : jtbs_pkg::RTI;
            jtbs_pkg::SEL_IR: tap_nxt = filt_nxt.tms ? jtbs_pkg::TLR : jtbs_pkg::CAP_IR;
            jtbs_pkg::CAP_IR: tap_nxt = filt_nxt.tms ? jtbs_pkg::EX1_IR : jtbs_pkg::SH_IR;
            jtbs_pkg::SH_IR: tap_nxt = filt_nxt.tms ? jtbs_pkg::EX1_IR : jtbs_pkg::SH_IR;
            jtbs_pkg::EX1_IR: tap_nxt = filt_nxt.tms ? jtbs_pkg::UPD_IR : jtbs_pkg::PAU_IR;
            jtbs_pkg::PAU_IR: tap_nxt = filt_nxt.tms ? jtbs_pkg::EX2_IR : jtbs_pkg::PAU_IR;
            jtbs_pkg::EX2_IR: tap_nxt = filt_nxt.tms ? jtbs_pkg::UPD_IR : jtbs_pkg::SH_IR;
            jtbs_pkg::UPD_IR: tap_nxt = filt_nxt.tms ? jtbs_pkg::SEL_DR : jtbs_pkg::RTI;
            default: tap_nxt = jtbs_pkg::TLR;
        endcase
    end

    // port held in reset while the pins serve the user
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tap_r <= jtbs_pkg::TLR;
        end else if (clk_en_i && !jtag_en_i) begin
            tap_r <= jtbs_pkg::TLR;
        end else if (tck_rise) begin
            tap_r <= tap_nxt;
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ir_sh_r <= '0;
            ir_r <= jtbs_pkg::IR_RESET;
        end else if (clk_en_i && (!jtag_en_i || tap_r == jtbs_pkg::TLR)) begin
            ir_r <= jtbs_pkg::IR_RESET;
        end else if (tck_rise) begin
            if (tap_r == jtbs_pkg::CAP_IR) ir_sh_r <= jtbs_pkg::IR_CAPTURE;
            else if (tap_r == jtbs_pkg::SH_IR) ir_sh_r <= {filt_nxt.tdi, ir_sh_r[9:1]};
            else if (tap_r == jtbs_pkg::UPD_IR) ir_r <= ir_sh_r;
        end
    end

    // general data shift, capture by instruction, lsb out first
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dr_sh_r <= '0;
        end else if (tck_rise && tap_r == jtbs_pkg::CAP_DR) begin
            if (is_op(ir_r, jtbs_pkg::OP_IDCODE)) dr_sh_r <= IDCODE_VAL;
            // user code only on enhanced parts
            else if (ENHANCED && is_op(ir_r, jtbs_pkg::OP_USERCODE)) dr_sh_r <= usercode_i;
            // signature read and write share one path
            else if (is_op(ir_r, jtbs_pkg::OP_SIG_READ) || is_op(ir_r, jtbs_pkg::OP_SIG_WRITE))
                dr_sh_r <= {16'h0000, user_sig_o};
            else dr_sh_r <= '0;
        end else if (tck_rise && tap_r == jtbs_pkg::SH_DR) begin
            dr_sh_r <= {filt_nxt.tdi, dr_sh_r[31:1]};
        end
    end

    // boundary chain, length set by variant
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bsr_sh_r <= '0;
            bsr_update_o <= '0;
        end else if (tck_rise && (is_op(ir_r, jtbs_pkg::OP_EXTEST) || is_op(ir_r, jtbs_pkg::OP_SAMPLE))) begin
            if (tap_r == jtbs_pkg::CAP_DR) bsr_sh_r <= bsr_capture_i;
            else if (tap_r == jtbs_pkg::SH_DR) bsr_sh_r <= {filt_nxt.tdi, bsr_sh_r[BSR_LEN-1:1]};
            else if (tap_r == jtbs_pkg::UPD_DR) bsr_update_o <= bsr_sh_r;
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            user_sig_o <= jtbs_pkg::SIG_RESET;
        end else if (tck_rise && tap_r == jtbs_pkg::UPD_DR && is_op(ir_r, jtbs_pkg::OP_SIG_WRITE)) begin
            user_sig_o <= dr_sh_r[31:16];
        end
    end

    // programming mode entered and left by instruction; test reset leaves it
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            prog_r <= 1'b0;
        end else if (clk_en_i && (!jtag_en_i || tap_r == jtbs_pkg::TLR)) begin
            prog_r <= 1'b0;
        end else if (tck_rise && tap_r == jtbs_pkg::UPD_IR) begin
            if (ir_sh_r == jtbs_pkg::OP_PROG_ENTER) prog_r <= 1'b1;
            else if (ir_sh_r == jtbs_pkg::OP_PROG_EXIT) prog_r <= 1'b0;
        end
    end

    // tdo changes on the falling test clock, safe for the far sampler
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tdo_o <= 1'b0;
            tdo_oe_o <= 1'b0;
        end else if (clk_en_i && !jtag_en_i) begin
            tdo_oe_o <= 1'b0;
        end else if (tck_fall) begin
            tdo_oe_o <= (tap_r == jtbs_pkg::SH_DR) || (tap_r == jtbs_pkg::SH_IR);
            if (tap_r == jtbs_pkg::SH_IR) tdo_o <= ir_sh_r[0];
            else if (is_op(ir_r, jtbs_pkg::OP_EXTEST) || is_op(ir_r, jtbs_pkg::OP_SAMPLE)) tdo_o <= bsr_sh_r[0];
            else tdo_o <= dr_sh_r[0];
        end
    end

    // pins released while programming, weak pull-up on
    // no user drive until programming completes, on enhanced parts only
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            io_oe_o <= '0;
            io_pullup_o <= 1'b0;
            prog_active_o <= 1'b0;
            test_pins_user_o <= 1'b0;
        end else if (clk_en_i) begin
            io_oe_o <= (prog_r || (ENHANCED && !programming_complete_flag_i)) ? '0 : user_oe_i;
            io_pullup_o <= prog_r;
            prog_active_o <= prog_r;
            test_pins_user_o <= !jtag_en_i;
        end
    end

    // checks
    property p_ir_cap;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        (tck_rise && tap_r == jtbs_pkg::CAP_IR && jtag_en_i) |=> ir_sh_r == 10'h001;
    endproperty
    a_ir_cap: assert property (p_ir_cap) else $error("instruction capture wrong");
    property p_id_cap;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        (tck_rise && tap_r == jtbs_pkg::CAP_DR && ir_r == jtbs_pkg::OP_IDCODE) |=> dr_sh_r == IDCODE_VAL;
    endproperty
    a_id_cap: assert property (p_id_cap) else $error("id code not captured");
    property p_id_lsb;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        (tck_rise && tap_r == jtbs_pkg::CAP_DR && ir_r == jtbs_pkg::OP_IDCODE) |=> dr_sh_r[0] == 1'b1;
    endproperty
    a_id_lsb: assert property (p_id_lsb) else $error("id code lsb not one");
    property p_shift;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        (tck_rise && tap_r == jtbs_pkg::SH_DR && jtag_en_i) |=> dr_sh_r[30:0] == $past(dr_sh_r[31:1]);
    endproperty
    a_shift: assert property (p_shift) else $error("data shift not lsb first");
    property p_ucode;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        (tck_rise && tap_r == jtbs_pkg::CAP_DR && ir_r == jtbs_pkg::OP_USERCODE && ENHANCED)
        |=> dr_sh_r == $past(usercode_i);
    endproperty
    a_ucode: assert property (p_ucode) else $error("user code not captured");
    property p_sig;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        (tck_rise && tap_r == jtbs_pkg::UPD_DR && ir_r == jtbs_pkg::OP_SIG_WRITE) |=> user_sig_o == $past(dr_sh_r[31:16]);
    endproperty
    a_sig: assert property (p_sig) else $error("signature not written");
    property p_prog_hiz;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        (prog_r && clk_en_i) |=> (io_oe_o == '0) && io_pullup_o;
    endproperty
    a_prog_hiz: assert property (p_prog_hiz) else $error("pins driven while programming");
    property p_done;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        (ENHANCED && !programming_complete_flag_i && clk_en_i) |=> io_oe_o == '0;
    endproperty
    a_done: assert property (p_done) else $error("pins driven before completion");
    property p_user_pins;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        (!jtag_en_i && clk_en_i) |=> tap_r == jtbs_pkg::TLR && !tdo_oe_o && test_pins_user_o;
    endproperty
    a_user_pins: assert property (p_user_pins) else $error("test pins not released");
    property p_exit;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        (tck_rise && jtag_en_i && filt_nxt.tms && tap_r == jtbs_pkg::SH_DR) |=> tap_r == jtbs_pkg::EX1_DR;
    endproperty
    a_exit: assert property (p_exit) else $error("shift exit wrong");
    c_id: cover property (@(posedge ref_clk_i) tap_r == jtbs_pkg::SH_DR && ir_r == jtbs_pkg::OP_IDCODE);
    c_prog: cover property (@(posedge ref_clk_i) prog_r);
    c_sig: cover property (@(posedge ref_clk_i) tap_r == jtbs_pkg::UPD_DR && ir_r == jtbs_pkg::OP_SIG_WRITE);
endmodule

`default_nettype wire

// [verification/jtbs_host.sv]
// behavioural test-port host driving the four-wire link
`timescale 1ns/1ns
`default_nettype none
module jtbs_host (
    input wire logic ref_clk_i,
    input wire logic tdo_i,
    input wire logic tdo_oe_i,
    output logic tck_o,
    output logic tms_o,
    output logic tdi_o,
    output logic oe_ok_o,
    output logic res_vld_o,
    output logic [95:0] res_o
);
    // link idles with tck still, tms and tdi at their pull-up level
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b1;
        oe_ok_o = 1'b1;
        res_vld_o = 1'b0;
        res_o = '0;
    end

    // 80 ns link cycle: low 48 ns, high 32 ns, both above the 3-clock filter
    task automatic cyc(input logic ms, input logic di, input logic sh, output logic bit_o);
        repeat (2) @(negedge ref_clk_i);
        tms_o = ms;
        tdi_o = di;
        repeat (4) @(negedge ref_clk_i);
        // tdo read late in the low phase, it moves 3.5 clocks after the fall
        bit_o = tdo_i;
        if (sh && tdo_oe_i !== 1'b1) oe_ok_o = 1'b0;
        tck_o = 1'b1;
        repeat (4) @(negedge ref_clk_i);
        tck_o = 1'b0;
    endtask

    task automatic go_idle();
        logic b;
        repeat (5) cyc(1'b1, 1'b1, 1'b0, b);
        cyc(1'b0, 1'b1, 1'b0, b);
    endtask

    // whole instruction or data word clocked in from idle
    task automatic scan(input logic ir, input int n, input logic [95:0] din);
        logic b;
        logic [95:0] q;
        q = '0;
        oe_ok_o = 1'b1;
        cyc(1'b1, 1'b1, 1'b0, b);
        if (ir) cyc(1'b1, 1'b1, 1'b0, b);
        cyc(1'b0, 1'b1, 1'b0, b);
        cyc(1'b0, 1'b1, 1'b0, b);
        for (int i = 0; i < n; i++) begin
            cyc(i == n - 1, din[i], 1'b1, b);
            q[i] = b;
        end
        cyc(1'b1, 1'b1, 1'b0, b);
        cyc(1'b0, 1'b1, 1'b0, b);
        tms_o = 1'b1;
        tdi_o = 1'b1;
        res_o = q;
        res_vld_o = 1'b1;
        @(negedge ref_clk_i);
        res_vld_o = 1'b0;
    endtask
endmodule
`default_nettype wire

// [verification/jtbs_tb_top.sv]
// self-checking bench of the test access port with its host model
`timescale 1ns/1ns
`default_nettype none
module jtag_boundary_scan_isp_port_tb_top;
    localparam int BL = 96;
    localparam logic [31:0] IDC = {jtbs_pkg::ID_VERSION, jtbs_pkg::ID_PART, jtbs_pkg::ID_MAKER, jtbs_pkg::ID_ONE};
    logic ref_clk_i, nrst_i, clk_en_i, jtag_en_i, flag_i, tck, tms, tdi, tdo_o, tdo_oe_o;
    logic test_pins_user_o, prog_active_o, io_pullup_o, oe_ok, res_vld;
    logic [31:0] usercode_i;
    logic [BL-1:0] bsr_capture_i, bsr_update_o;
    logic [7:0] user_oe_i, io_oe_o;
    logic [15:0] user_sig_o, sig_exp;
    logic [95:0] res, din, got_exp;
    logic [95:0] exp_q[$];
    logic [9:0] ops[8];
    int err_total, num_checks, cyc_cnt;

    jtbs_port #(.BSR_LEN(BL), .ENHANCED(1'b1), .NUM_IO(8)) i_dut (
        .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .clk_en_i(clk_en_i), .jtag_en_i(jtag_en_i),
        .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .programming_complete_flag_i(flag_i),
        .usercode_i(usercode_i), .bsr_capture_i(bsr_capture_i), .user_oe_i(user_oe_i),
        .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .test_pins_user_o(test_pins_user_o),
        .prog_active_o(prog_active_o), .io_pullup_o(io_pullup_o), .io_oe_o(io_oe_o),
        .user_sig_o(user_sig_o), .bsr_update_o(bsr_update_o)
    );
    jtbs_host i_host (
        .ref_clk_i(ref_clk_i), .tdo_i(tdo_o), .tdo_oe_i(tdo_oe_o), .tck_o(tck), .tms_o(tms),
        .tdi_o(tdi), .oe_ok_o(oe_ok), .res_vld_o(res_vld), .res_o(res)
    );

    task automatic conclude();
        if (err_total == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [95:0] exp, input logic [95:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", nm, exp, got);
            err_total++;
        end
    endtask

    // instruction load, the captured pattern comes back out
    task automatic load_ir(input logic [9:0] op);
        exp_q.push_back({86'h0, jtbs_pkg::IR_CAPTURE});
        i_host.scan(1'b1, 10, {86'h0, op});
    endtask

    // 125 MHz system clock
    initial begin
        ref_clk_i = 1'b0;
        forever #4 ref_clk_i = ~ref_clk_i;
    end

    // budget counts system clocks, about 11k needed
    always @(posedge ref_clk_i) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 60000) begin
            err_total++;
            conclude();
        end
    end

    // each scan result is matched against the oldest note
    always @(posedge ref_clk_i) begin
        if (res_vld === 1'b1) begin
            got_exp = (exp_q.size() > 0) ? exp_q.pop_front() : 'x;
            num_checks++;
            if (res !== got_exp || oe_ok !== 1'b1) begin
                $display("Error scan expected %h seen %h oe %b", got_exp, res, oe_ok);
                err_total++;
            end
        end
    end

    // main sequence; the unknown opcode must give a zero chain
    initial begin
        nrst_i = 1'b0;
        clk_en_i = 1'b1;
        jtag_en_i = 1'b1;
        flag_i = 1'b1;
        usercode_i = '0;
        bsr_capture_i = '0;
        user_oe_i = '0;
        sig_exp = jtbs_pkg::SIG_RESET;
        // adaptive: signature written, then read back
        ops = '{jtbs_pkg::OP_SIG_WRITE, jtbs_pkg::OP_SIG_READ, jtbs_pkg::OP_USERCODE, jtbs_pkg::OP_SAMPLE,
                jtbs_pkg::OP_EXTEST, jtbs_pkg::OP_BYPASS, 10'h123, jtbs_pkg::OP_IDCODE};
        void'($urandom(61));
        repeat (20) @(negedge ref_clk_i);
        nrst_i = 1'b1;
        @(negedge ref_clk_i);
        chk("user_sig_o", 96'(jtbs_pkg::SIG_RESET), 96'(user_sig_o));
        // port off: pins go to the user, enables still gated by the flag
        jtag_en_i = 1'b0;
        user_oe_i = 8'($urandom());
        repeat (2) @(negedge ref_clk_i);
        chk("test_pins_user_o", 96'(1), 96'(test_pins_user_o));
        chk("io_oe_o", 96'(user_oe_i), 96'(io_oe_o));
        flag_i = 1'b0;
        repeat (2) @(negedge ref_clk_i);
        chk("io_oe_o", 96'(0), 96'(io_oe_o));
        flag_i = 1'b1;
        jtag_en_i = 1'b1;
        repeat (2) @(negedge ref_clk_i);
        chk("test_pins_user_o", 96'(0), 96'(test_pins_user_o));
        // enable low freezes the port, so the release must not show
        clk_en_i = 1'b0;
        jtag_en_i = 1'b0;
        repeat (2) @(negedge ref_clk_i);
        chk("test_pins_user_o", 96'(0), 96'(test_pins_user_o));
        jtag_en_i = 1'b1;
        clk_en_i = 1'b1;
        repeat (2) @(negedge ref_clk_i);
        // default instruction reads the id code, 32-bit path length
        din = {$urandom(), $urandom(), $urandom()};
        i_host.go_idle();
        exp_q.push_back({din[63:0], IDC});
        i_host.scan(1'b0, 96, din);
        foreach (ops[k]) begin
            usercode_i = $urandom();
            bsr_capture_i = {$urandom(), $urandom(), $urandom()};
            load_ir(ops[k]);
            din = {$urandom(), $urandom(), $urandom()};
            case (ops[k])
                jtbs_pkg::OP_SIG_WRITE, jtbs_pkg::OP_SIG_READ: exp_q.push_back({din[63:0], 16'h0000, sig_exp});
                jtbs_pkg::OP_USERCODE: exp_q.push_back({din[63:0], usercode_i});
                jtbs_pkg::OP_SAMPLE, jtbs_pkg::OP_EXTEST: exp_q.push_back(bsr_capture_i);
                jtbs_pkg::OP_IDCODE: exp_q.push_back({din[63:0], IDC});
                default: exp_q.push_back({din[63:0], 32'h0000_0000});
            endcase
            i_host.scan(1'b0, 96, din);
            if (ops[k] == jtbs_pkg::OP_SIG_WRITE) sig_exp = din[95:80];
            chk("user_sig_o", 96'(sig_exp), 96'(user_sig_o));
            if (ops[k] == jtbs_pkg::OP_SAMPLE || ops[k] == jtbs_pkg::OP_EXTEST) chk("bsr_update_o", din, bsr_update_o);
        end
        // programming floats the user pins with pull-up, exit restores them
        user_oe_i = 8'hFF;
        load_ir(jtbs_pkg::OP_PROG_ENTER);
        chk("prog_active_o", 96'(1), 96'(prog_active_o));
        chk("io_pullup_o", 96'(1), 96'(io_pullup_o));
        chk("io_oe_o", 96'(0), 96'(io_oe_o));
        load_ir(jtbs_pkg::OP_PROG_EXIT);
        chk("io_pullup_o", 96'(0), 96'(io_pullup_o));
        chk("io_oe_o", 96'(8'hFF), 96'(io_oe_o));
        // test-logic reset also ends programming
        load_ir(jtbs_pkg::OP_PROG_ENTER);
        i_host.go_idle();
        chk("prog_active_o", 96'(0), 96'(prog_active_o));
        conclude();
    end
endmodule
`default_nettype wire
